// ---- rtl/sfd_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfd_core
   import sfd_pkg::*;
#(
   parameter int STACK_DEPTH = 256
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // operation issue
   input  wire logic              op_valid,
   input  wire sfd_op_t           op_code,
   input  wire logic [7:0]        op_operand,
   input  wire logic [15:0]       op_pointer,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   // state seen by the rest of the core
   output logic      [7:0]        processor_status_register,
   output logic      [7:0]        stack_pointer,
   output logic      [7:0]        accumulator,
   output logic                   nvz_valid,
   output logic      [15:0]       jump_ptr_lo_addr,
   output logic      [15:0]       jump_ptr_hi_addr
);

   // ------------------------------------------------------------
   // operation decode
   // ------------------------------------------------------------
   wire logic is_add  = op_valid && (op_code == SFD_OP_ADD);
   wire logic is_sub  = op_valid && (op_code == SFD_OP_SUBTRACT_WITH_BORROW);
   wire logic is_inc  = op_valid && (op_code == SFD_OP_INCREMENT);
   wire logic is_push = op_valid && (op_code == SFD_OP_PUSH_STATUS);
   wire logic is_pull = op_valid && (op_code == SFD_OP_PULL_STATUS);
   wire logic is_jind = op_valid && (op_code == SFD_OP_JUMP_INDIRECT);
   wire logic is_arith = is_add || is_sub;
   wire logic decimal  = processor_status_register[FLAG_D];
   wire logic carry_in = processor_status_register[FLAG_C];

   // ------------------------------------------------------------
   // binary path
   // ------------------------------------------------------------
   wire logic [7:0] bin_b   = is_sub ? ~op_operand : op_operand;
   wire logic [8:0] bin_sum = {1'b0, accumulator} + {1'b0, bin_b} + {8'h00, carry_in};
   wire logic       bin_v   = (accumulator[7] == bin_b[7]) && (bin_sum[7] != accumulator[7]);

   // ------------------------------------------------------------
   // decimal path, one digit adjuster per nibble
   // ------------------------------------------------------------
   // nets, since each digit adjuster drives its own slice
   wire logic [7:0] dec_res;
   wire logic [2:0] dec_chain;
   assign dec_chain[0] = is_sub ? ~carry_in : carry_in;

   for (genvar g = 0; g < 2; g++) begin : g_digit
      sfd_bcd_digit u_digit (
         .a     (accumulator[4*g +: 4]),
         .b     (op_operand[4*g +: 4]),
         .cin   (dec_chain[g]),
         .sub   (is_sub),
         .digit (dec_res[4*g +: 4]),
         .cout  (dec_chain[g+1])
      );
   end

   // carry means no borrow on subtract
   wire logic dec_carry = is_sub ? ~dec_chain[2] : dec_chain[2];

   wire logic       use_dec   = decimal && is_arith;
   wire logic [7:0] arith_res = use_dec ? dec_res : bin_sum[7:0];
   wire logic       arith_c   = use_dec ? dec_carry : bin_sum[8];
   wire logic [7:0] inc_res   = accumulator + BYTE_ONE;

   // ------------------------------------------------------------
   // stack page
   // ------------------------------------------------------------
   logic [7:0] stack_mem [STACK_DEPTH];
   wire logic [7:0] sp_next_up = stack_pointer + BYTE_ONE;
   wire logic [7:0] sp_next_dn = stack_pointer - BYTE_ONE;
   wire logic       reg_mem    = reg_addr[ADDR_MEM_BIT];
   wire logic [7:0] reg_off    = reg_addr[7:0];

   // a push and a software write in the same cycle: the push owns the stack
   always_ff @(posedge clk) begin
      if (is_push) begin
         stack_mem[stack_pointer] <= processor_status_register;
      end else if (reg_wr && reg_mem) begin
         stack_mem[reg_off] <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // status register next value
   // ------------------------------------------------------------
   logic [7:0] next_status;
   always_comb begin
      next_status = processor_status_register;
      if (reg_wr && !reg_mem && (reg_addr == ADDR_STATUS)) begin
         next_status = reg_wdata;
      end
      if (op_valid) begin
         unique case (op_code)
            SFD_OP_ADD, SFD_OP_SUBTRACT_WITH_BORROW: begin
               next_status[FLAG_C] = arith_c;
               next_status[FLAG_Z] = (arith_res == ACC_RESET);
               next_status[FLAG_N] = arith_res[7];
               next_status[FLAG_V] = bin_v;
            end
            SFD_OP_INCREMENT: begin
               next_status[FLAG_Z] = (inc_res == ACC_RESET);
               next_status[FLAG_N] = inc_res[7];
            end
            SFD_OP_SET_CARRY:     next_status[FLAG_C] = 1'b1;
            SFD_OP_CLEAR_CARRY:   next_status[FLAG_C] = 1'b0;
            SFD_OP_SET_DECIMAL:   next_status[FLAG_D] = 1'b1;
            SFD_OP_CLEAR_DECIMAL: next_status[FLAG_D] = 1'b0;
            SFD_OP_SET_INDEX:     next_status[FLAG_T] = 1'b1;
            SFD_OP_CLEAR_INDEX:   next_status[FLAG_T] = 1'b0;
            SFD_OP_PULL_STATUS:   next_status = stack_mem[sp_next_up];
            SFD_OP_NONE, SFD_OP_PUSH_STATUS, SFD_OP_JUMP_INDIRECT,
            SFD_OP_NO_OPERATION: ;
            // the two spare codes of the field change nothing
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   wire logic wr_sp  = reg_wr && !reg_mem && (reg_addr == ADDR_SP);
   wire logic wr_acc = reg_wr && !reg_mem && (reg_addr == ADDR_ACC);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         processor_status_register <= STATUS_RESET;
      end else begin
         processor_status_register <= next_status;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stack_pointer <= SP_RESET;
      end else if (is_push) begin
         stack_pointer <= sp_next_dn;
      end else if (is_pull) begin
         stack_pointer <= sp_next_up;
      end else if (wr_sp) begin
         stack_pointer <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         accumulator <= ACC_RESET;
      end else if (is_arith) begin
         accumulator <= arith_res;
      end else if (is_inc) begin
         accumulator <= inc_res;
      end else if (wr_acc) begin
         accumulator <= reg_wdata;
      end
   end

   // n, v and z carry no meaning after decimal arithmetic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         nvz_valid <= 1'b0;
      end else if (is_arith || is_inc) begin
         nvz_valid <= !use_dec;
      end else if (is_pull || (next_status != processor_status_register)) begin
         nvz_valid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // indirect jump pointer addresses
   // ------------------------------------------------------------
   // the low byte wraps inside the page; pointers at a page end misfetch
   wire logic [15:0] ptr_hi_same_page = {op_pointer[15:8], op_pointer[7:0] + BYTE_ONE};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         jump_ptr_lo_addr <= 16'h0000;
         jump_ptr_hi_addr <= 16'h0000;
      end else if (is_jind) begin
         jump_ptr_lo_addr <= op_pointer;
         jump_ptr_hi_addr <= ptr_hi_same_page;
      end
   end

   // ------------------------------------------------------------
   // register port read, data in the cycle after the strobe
   // ------------------------------------------------------------
   logic [7:0] read_sel;
   always_comb begin
      read_sel = ACC_RESET;
      if (reg_mem) begin
         read_sel = stack_mem[reg_off];
      end else if (reg_addr == ADDR_STATUS) begin
         read_sel = processor_status_register;
      end else if (reg_addr == ADDR_SP) begin
         read_sel = stack_pointer;
      end else if (reg_addr == ADDR_ACC) begin
         read_sel = accumulator;
      end else if (reg_addr == ADDR_VALID) begin
         read_sel = {7'h00, nvz_valid};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= read_sel;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // are kept by software; pull takes effect at once so
   // the following no-operation only buys the sequencer its settling slot

endmodule : sfd_core
`default_nettype wire

// ---- rtl/sfd_pkg.sv ----
package sfd_pkg;

   // ------------------------------------------------------------
   // status register bit positions
   // ------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_I = 2;
   localparam int FLAG_D = 3;
   localparam int FLAG_B = 4;
   localparam int FLAG_T = 5;
   localparam int FLAG_V = 6;
   localparam int FLAG_N = 7;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_RESET = 8'h04;
   localparam logic [7:0] SP_RESET     = 8'hff;
   localparam logic [7:0] ACC_RESET    = 8'h00;

   // ------------------------------------------------------------
   // register port map
   // ------------------------------------------------------------
   localparam int          ADDR_W       = 9;
   localparam logic [8:0]  ADDR_STATUS  = 9'h000;
   localparam logic [8:0]  ADDR_SP      = 9'h001;
   localparam logic [8:0]  ADDR_ACC     = 9'h002;
   localparam logic [8:0]  ADDR_VALID   = 9'h003;
   localparam int          ADDR_MEM_BIT = 8;

   // ------------------------------------------------------------
   // decimal digit constants and the byte increment
   // ------------------------------------------------------------
   localparam logic [4:0] BCD_MAX = 5'h09;
   localparam logic [4:0] BCD_FIX = 5'h06;
   localparam logic [7:0] BYTE_ONE = 8'h01;

   // ------------------------------------------------------------
   // operations issued by the sequencer
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      SFD_OP_NONE,
      SFD_OP_ADD,
      SFD_OP_SUBTRACT_WITH_BORROW,
      SFD_OP_INCREMENT,
      SFD_OP_SET_CARRY,
      SFD_OP_CLEAR_CARRY,
      SFD_OP_SET_DECIMAL,
      SFD_OP_CLEAR_DECIMAL,
      SFD_OP_SET_INDEX,
      SFD_OP_CLEAR_INDEX,
      SFD_OP_PUSH_STATUS,
      SFD_OP_PULL_STATUS,
      SFD_OP_JUMP_INDIRECT,
      SFD_OP_NO_OPERATION
   } sfd_op_t;

endpackage : sfd_pkg

// ---- rtl/sfd_bcd_digit.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfd_bcd_digit
   import sfd_pkg::*;
(
   // operands
   input  wire logic [3:0] a,
   input  wire logic [3:0] b,
   input  wire logic       cin,
   input  wire logic       sub,
   // result
   output logic      [3:0] digit,
   output logic            cout
);

   wire logic [4:0] sum_raw  = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   wire logic [4:0] diff_raw = {1'b0, a} - {1'b0, b} - {4'h0, cin};
   wire logic       add_over = sum_raw > BCD_MAX;
   wire logic [4:0] sum_fix  = sum_raw + BCD_FIX;
   wire logic [4:0] diff_fix = diff_raw - BCD_FIX;

   // cin and cout mean borrow when sub is high
   assign digit = sub ? (diff_raw[4] ? diff_fix[3:0] : diff_raw[3:0])
                      : (add_over ? sum_fix[3:0] : sum_raw[3:0]);
   assign cout  = sub ? diff_raw[4] : add_over;

endmodule : sfd_bcd_digit
`default_nettype wire

// ---- dv/sfd_core_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfd_core_props
   import sfd_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // operation issue
   input wire logic        op_valid,
   input wire sfd_op_t     op_code,
   input wire logic [7:0]  op_operand,
   input wire logic [15:0] op_pointer,
   // core state
   input wire logic [7:0]  processor_status_register,
   input wire logic [7:0]  stack_pointer,
   input wire logic [7:0]  accumulator,
   input wire logic        nvz_valid,
   input wire logic [15:0] jump_ptr_lo_addr,
   input wire logic [15:0] jump_ptr_hi_addr
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire logic        dec       = processor_status_register[FLAG_D];
   wire logic        carry     = processor_status_register[FLAG_C];
   // bcd order matches hex order, so a plain compare predicts the borrow
   wire logic        no_borrow = accumulator >= op_operand;
   wire logic [15:0] next_hi   = {op_pointer[15:8], op_pointer[7:0] + 8'h01};
   wire logic        go        = op_valid;
   property p_reset_status;
      $rose(rstn) |-> processor_status_register == STATUS_RESET;
   endproperty
   a_reset_status: assert property (p_reset_status) else $error("status not reset");
   property p_push;
      go && op_code == SFD_OP_PUSH_STATUS |=> stack_pointer == $past(stack_pointer) - 8'h01;
   endproperty
   a_push: assert property (p_push) else $error("push pointer wrong");
   property p_pull;
      go && op_code == SFD_OP_PULL_STATUS |=> stack_pointer == $past(stack_pointer) + 8'h01 && !nvz_valid;
   endproperty
   a_pull: assert property (p_pull) else $error("pull pointer wrong");
   property p_set_dec;
      go && op_code == SFD_OP_SET_DECIMAL |=> dec;
   endproperty
   a_set_dec: assert property (p_set_dec) else $error("decimal flag not set");
   property p_inc;
      go && op_code == SFD_OP_INCREMENT |=> accumulator == $past(accumulator) + 8'h01 && carry == $past(carry);
   endproperty
   a_inc: assert property (p_inc) else $error("increment adjusted");
   property p_nvz;
      go && (op_code == SFD_OP_ADD || op_code == SFD_OP_SUBTRACT_WITH_BORROW) |=> nvz_valid == !$past(dec);
   endproperty
   a_nvz: assert property (p_nvz) else $error("nvz marking wrong");
   property p_dec_borrow;
      go && op_code == SFD_OP_SUBTRACT_WITH_BORROW && dec && carry |=> carry == $past(no_borrow);
   endproperty
   a_dec_borrow: assert property (p_dec_borrow) else $error("decimal borrow carry wrong");
   property p_jump;
      go && op_code == SFD_OP_JUMP_INDIRECT |=> jump_ptr_lo_addr == $past(op_pointer) && jump_ptr_hi_addr == $past(next_hi);
   endproperty
   a_jump: assert property (p_jump) else $error("pointer high byte address wrong");
endmodule : sfd_core_props
bind sfd_core sfd_core_props i_sfd_core_props (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
   .op_operand(op_operand), .op_pointer(op_pointer), .processor_status_register(processor_status_register),
   .stack_pointer(stack_pointer), .accumulator(accumulator), .nvz_valid(nvz_valid),
   .jump_ptr_lo_addr(jump_ptr_lo_addr), .jump_ptr_hi_addr(jump_ptr_hi_addr));
`default_nettype wire

// ---- dv/sfd_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module sfd_core_tb
   import sfd_pkg::*;
;
   logic        clk = 1'b0, rstn = 1'b0, op_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, nvz;
   sfd_op_t     op_code = SFD_OP_NONE;
   logic [7:0]  op_operand = 8'h00, reg_wdata = 8'h00, reg_rdata, psr, sp, acc;
   logic [15:0] op_pointer = 16'h0000, jlo, jhi;
   logic [8:0]  reg_addr = 9'h000;
   int          err_total = 0, tests_run = 0;
   always #20 clk = ~clk;
   sfd_core i_sfd_core (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
      .op_operand(op_operand), .op_pointer(op_pointer), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .processor_status_register(psr),
      .stack_pointer(sp), .accumulator(acc), .nvz_valid(nvz), .jump_ptr_lo_addr(jlo), .jump_ptr_hi_addr(jhi));
   // ------------------------------------------------------------
   // drivers
   // ------------------------------------------------------------
   task automatic op(input sfd_op_t c, input logic [7:0] d = 8'h00, input logic [15:0] p = 16'h0000);
      @(posedge clk);
      op_valid   <= 1'b1;
      op_code    <= c;
      op_operand <= d;
      op_pointer <= p;
      @(posedge clk);
      op_valid   <= 1'b0;
      #1;
   endtask : op
   // read data stand one cycle only, so they are taken right after the edge
   task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d = 8'h00);
      @(posedge clk);
      reg_wr    <= w;
      reg_rd    <= !w;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      #1;
   endtask : bus
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      `CHK("status", STATUS_RESET, psr)
      bus(1'b0, ADDR_STATUS);
      `CHK("status read", 8'h04, reg_rdata)
      `CHK("sp", 8'hff, sp)
      `CHK("nvz reset", 1'b0, nvz)
      $display("t_reset done");
   endtask : t_reset
   task automatic t_stack;
      bus(1'b1, ADDR_STATUS, 8'h0b);
      op(SFD_OP_PUSH_STATUS);
      `CHK("sp push", 8'hfe, sp)
      bus(1'b0, {1'b1, sp + 8'h01});
      `CHK("stacked status", 8'h0b, reg_rdata)
      op(SFD_OP_CLEAR_CARRY);
      op(SFD_OP_CLEAR_DECIMAL);
      `CHK("status cleared", 8'h02, psr)
      op(SFD_OP_PULL_STATUS);
      op(SFD_OP_NO_OPERATION);
      `CHK("status pulled", 8'h0b, psr)
      `CHK("sp pull", 8'hff, sp)
      bus(1'b0, 9'h004);
      `CHK("unmapped", 8'h00, reg_rdata)
      $display("t_stack done");
   endtask : t_stack
   task automatic t_decimal;
      logic [7:0] ta[4] = '{8'h58, 8'h12, 8'h46, 8'h12};
      logic [7:0] tb[4] = '{8'h46, 8'h34, 8'h12, 8'h46};
      logic [7:0] tr[4] = '{8'h05, 8'h46, 8'h34, 8'h66};
      logic [3:0] tc    = 4'b1101;
      logic [3:0] tco   = 4'b0101;
      op(SFD_OP_SET_INDEX);
      `CHK("index set", 1'b1, psr[FLAG_T])
      op(SFD_OP_CLEAR_INDEX);
      `CHK("index clear", 1'b0, psr[FLAG_T])
      op(SFD_OP_SET_DECIMAL);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, ADDR_ACC, ta[i]);
         op(tc[i] ? SFD_OP_SET_CARRY : SFD_OP_CLEAR_CARRY);
         op(i < 2 ? SFD_OP_ADD : SFD_OP_SUBTRACT_WITH_BORROW, tb[i]);
         `CHK("bcd result", tr[i], acc)
         `CHK("bcd carry", tco[i], psr[FLAG_C])
         `CHK("nvz invalid", 1'b0, nvz)
         op(SFD_OP_NO_OPERATION);
      end
      bus(1'b1, ADDR_ACC, 8'h09);
      op(SFD_OP_INCREMENT);
      `CHK("inc not adjusted", 8'h0a, acc)
      op(SFD_OP_CLEAR_DECIMAL);
      op(SFD_OP_CLEAR_CARRY);
      bus(1'b1, ADDR_ACC, 8'h58);
      op(SFD_OP_ADD, 8'h46);
      `CHK("binary result", 8'h9e, acc)
      `CHK("nvz valid", 1'b1, nvz)
      bus(1'b0, ADDR_VALID);
      `CHK("valid read", 8'h01, reg_rdata)
      $display("t_decimal done");
   endtask : t_decimal
   task automatic t_jump;
      // page end pointers are avoided by software; here the wrap itself is probed
      op(SFD_OP_JUMP_INDIRECT, 8'h00, 16'h12ff);
      `CHK("ptr lo", 16'h12ff, jlo)
      `CHK("ptr hi wrap", 16'h1200, jhi)
      op(SFD_OP_JUMP_INDIRECT, 8'h00, 16'h3410);
      `CHK("ptr hi", 16'h3411, jhi)
      $display("t_jump done");
   endtask : t_jump
   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   initial begin
      #400000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      #1;
      t_reset();
      t_stack();
      t_decimal();
      t_jump();
      tally_and_finish();
   end
endmodule : sfd_core_tb
`default_nettype wire
